// *** clk_divider.sv ***
// Integer divider core with realign and duty shaping
`timescale 1ns/1ps
`default_nettype none
module clk_divider (
    input wire logic clk,
    input wire logic reset_n,
    div_if.core d
);
    logic [clkctl_pkg::DIV_W:0] hi_len;

    // Stopped or realigned divider sits in its initial state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            d.count <= clkctl_pkg::DIV_INIT;
        end else if (!d.run || d.realign) begin // [RULE4]
            d.count <= clkctl_pkg::DIV_INIT;
        end else if (d.count >= d.ratio_m1) begin // [RULE1]
            d.count <= clkctl_pkg::DIV_INIT;
        end else begin
            d.count <= d.count + 3'h1;
        end
    end

    always_comb begin
        hi_len = clkctl_pkg::high_len(d.ratio_m1, d.dcs_on);
        // Period starts on the rising, sampling edge
        d.tick = d.run && (d.count == clkctl_pkg::DIV_INIT); // [RULE14]
        // Falling edge moved to mid-period while stabilised
        d.phase_hi = d.run && ({1'b0, d.count} < hi_len); // [RULE5]
    end
endmodule
`default_nettype wire

// *** clkctl_pkg.sv ***
// Constants and types shared by the clock control block
`default_nettype none
package clkctl_pkg;
    localparam logic [12:0] SYNC_CFG_ADDR = 13'h0109;
    localparam logic [7:0] SYNC_CFG_RESET = 8'h00;
    localparam int SYNC_EN_BIT = 0;
    localparam int SYNC_ONCE_BIT = 1;
    localparam int SYNC_ARMED_BIT = 2;
    localparam int SYNC_SEEN_BIT = 3;
    localparam int DIV_W = 3;
    localparam int DIV_MIN = 1;
    localparam int DIV_MAX = 8;
    localparam logic [DIV_W-1:0] DIV_INIT = 3'h0;
    localparam int CLK_MHZ = 125;
    localparam int DCS_MIN_MHZ = 20;
    // Highest ratio whose divided rate still keeps the loop running
    localparam int DCS_MAX_DIV = CLK_MHZ / DCS_MIN_MHZ;
    localparam logic [DIV_W-1:0] DCS_MAX_M1 = DIV_W'(DCS_MAX_DIV - 1);
    localparam int RELOCK_NS = 1500;
    localparam int RELOCK_CYC = (RELOCK_NS * CLK_MHZ + 999) / 1000;
    localparam int RELOCK_W = 8;
    localparam logic [RELOCK_W-1:0] RELOCK_LOAD = RELOCK_W'(RELOCK_CYC);
    localparam int DWELL_W = 20;
    localparam int WAKE_SHIFT = 4;
    localparam int STBY_SHIFT = 6;

    typedef enum logic [3:0] {
        PWR_ON = 4'b0001,
        PWR_DOWN = 4'b0010,
        PWR_STBY = 4'b0100,
        PWR_WAKE = 4'b1000
    } pwr_state_t;

    // Cycles the divided clock stays high in one period
    function automatic logic [DIV_W:0] high_len(
        input logic [DIV_W-1:0] ratio_m1,
        input logic duty_cycle_stabilizer
    );
        logic [DIV_W:0] n;
        n = {1'b0, ratio_m1} + 4'h1;
        high_len = duty_cycle_stabilizer ? ((n + 4'h1) >> 1) : 4'h1;
    endfunction
endpackage
`default_nettype wire

// *** clock_control.sv ***
// Clock divider, alignment, duty stabiliser and power-down control
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE1] Divide the sample clock by any whole ratio from one to eight.
// [RULE2] An external alignment pulse realigns the divider phase.
// [RULE3] Config bits choose realign on every pulse or first after write.
// [RULE4] An accepted alignment pulse returns the divider to its initial state.
// [RULE5] Stabiliser retimes the falling edge for half-period high time.
// [RULE6] Stabiliser loop need not run below its lower input rate.
// [RULE7] Host waits the relock time after changing the clock rate.
// [RULE8] Power down when the pin or the serial control requests it.
// [RULE9] Output drivers go high impedance while powered down.
// [RULE10] Pin going low leaves pin power-down and resumes operation.
// [RULE11] Power-down shuts reference, its buffer, bias and clock.
// [RULE12] Serial-only standby keeps the reference on for faster wake.
// [RULE13] Wake-up time scales with the time spent powered down.
// [RULE14] Samples are taken on the rising internal clock edge.
// [RULE15] Alignment sampled on input clock; write re-arms one-shot mode.
// [RULE16] Stay powered down while either pin or register asks.
module clock_control (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SYNC_PIN,
    input wire logic POWERDOWN_PIN,
    input wire logic REG_WRITE,
    input wire logic [12:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [2:0] DIV_RATIO,
    input wire logic DCS_ENABLE,
    input wire logic SPI_POWERDOWN,
    input wire logic SPI_STANDBY,
    output logic [7:0] REG_RDATA,
    output logic INT_CLK,
    output logic SAMPLE_STROBE,
    output logic DCS_LOCKED,
    output logic OUT_OE_N,
    output logic REF_ON,
    output logic REF_BUF_ON,
    output logic BIAS_ON,
    output logic CLOCK_ON,
    output logic READY
);
    localparam int DW = clkctl_pkg::DWELL_W;

    div_if d ();
    logic sync_level;
    logic sync_rise;
    logic pd_pin;
    logic [7:0] cfg;
    logic armed;
    logic seen;
    logic wr_hit;
    logic accept;
    logic pd_req;
    logic stby_req;
    logic dcs_ok;
    logic dcs_prev;
    logic [2:0] ratio_prev;
    logic [clkctl_pkg::RELOCK_W-1:0] relock;
    logic locked;
    clkctl_pkg::pwr_state_t state;
    clkctl_pkg::pwr_state_t next_state;
    logic [DW-1:0] dwell;
    logic [DW-1:0] wake_cnt;

    // Alignment input sampled on the undivided clock
    pin_sync u_sync ( // [RULE15]
        .clk(CLK),
        .reset_n(RESET_N),
        .pin(SYNC_PIN),
        .level(sync_level),
        .rise(sync_rise)
    );

    pin_sync u_powerdown_pin (
        .clk(CLK),
        .reset_n(RESET_N),
        .pin(POWERDOWN_PIN),
        .level(pd_pin),
        .rise()
    );

    clk_divider u_div (
        .clk(CLK),
        .reset_n(RESET_N),
        .d(d.core)
    );

    assign wr_hit = REG_WRITE && (REG_ADDR == clkctl_pkg::SYNC_CFG_ADDR);
    // Once-only mode needs the one-shot armed by a config write
    assign accept = sync_rise && cfg[clkctl_pkg::SYNC_EN_BIT]
        && (!cfg[clkctl_pkg::SYNC_ONCE_BIT] || armed); // [RULE3]
    // Pin and register requests are ORed; the pin cannot be overridden
    assign pd_req = pd_pin || SPI_POWERDOWN; // [RULE16]
    assign stby_req = SPI_STANDBY && !pd_req; // [RULE12]
    // Loop is not run when the divided rate falls under its floor
    assign dcs_ok = DCS_ENABLE && (DIV_RATIO <= clkctl_pkg::DCS_MAX_M1)
        && (state == clkctl_pkg::PWR_ON); // [RULE6]
    assign locked = dcs_ok && (relock == '0);

    assign d.ratio_m1 = DIV_RATIO; // [RULE1]
    assign d.dcs_on = locked; // [RULE5]
    assign d.run = (state == clkctl_pkg::PWR_ON);
    assign d.realign = accept; // [RULE2]

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg <= clkctl_pkg::SYNC_CFG_RESET;
        end else if (wr_hit) begin
            cfg <= {6'h00, REG_WDATA[1:0]};
        end
    end

    // A write in the same cycle as an accepted pulse re-arms
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            armed <= 1'b0;
        end else if (wr_hit) begin
            armed <= 1'b1; // [RULE15]
        end else if (accept && cfg[clkctl_pkg::SYNC_ONCE_BIT]) begin
            armed <= 1'b0; // [RULE15]
        end
    end

    // Sticky flag of an accepted pulse; the event wins over the write
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            seen <= 1'b0;
        end else if (accept) begin
            seen <= 1'b1;
        end else if (wr_hit) begin
            seen <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA <= 8'h00;
        end else if (REG_ADDR == clkctl_pkg::SYNC_CFG_ADDR) begin
            REG_RDATA <= cfg;
            REG_RDATA[clkctl_pkg::SYNC_ARMED_BIT] <= armed;
            REG_RDATA[clkctl_pkg::SYNC_SEEN_BIT] <= seen;
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

    // Relock wait after a rate change models the loop time constant
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            relock <= clkctl_pkg::RELOCK_LOAD;
            dcs_prev <= 1'b0;
            ratio_prev <= clkctl_pkg::DIV_INIT;
        end else begin
            dcs_prev <= dcs_ok;
            ratio_prev <= DIV_RATIO;
            if (!dcs_ok || !dcs_prev || (DIV_RATIO != ratio_prev)) begin
                relock <= clkctl_pkg::RELOCK_LOAD; // [RULE7]
            end else if (relock != '0) begin
                relock <= relock - 8'h01;
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            clkctl_pkg::PWR_ON: begin
                if (pd_req) begin
                    next_state = clkctl_pkg::PWR_DOWN; // [RULE8]
                end else if (stby_req) begin
                    next_state = clkctl_pkg::PWR_STBY; // [RULE12]
                end
            end
            clkctl_pkg::PWR_DOWN: begin
                if (!pd_req) begin
                    next_state = stby_req ? clkctl_pkg::PWR_STBY
                        : clkctl_pkg::PWR_WAKE; // [RULE10]
                end
            end
            clkctl_pkg::PWR_STBY: begin
                if (pd_req) begin
                    next_state = clkctl_pkg::PWR_DOWN;
                end else if (!stby_req) begin
                    next_state = clkctl_pkg::PWR_WAKE;
                end
            end
            clkctl_pkg::PWR_WAKE: begin
                if (pd_req) begin
                    next_state = clkctl_pkg::PWR_DOWN;
                end else if (stby_req) begin
                    next_state = clkctl_pkg::PWR_STBY;
                end else if (wake_cnt == '0) begin
                    next_state = clkctl_pkg::PWR_ON;
                end
            end
            default: begin
                next_state = clkctl_pkg::PWR_DOWN;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= clkctl_pkg::PWR_ON;
        end else begin
            state <= next_state;
        end
    end

    // Dwell saturates rather than wraps, so long sleeps never wake fast
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dwell <= '0;
        end else if (state == clkctl_pkg::PWR_ON
            || state == clkctl_pkg::PWR_WAKE) begin
            dwell <= '0;
        end else if (dwell != '1) begin
            dwell <= dwell + 20'h00001;
        end
    end

    // Recharge time tracks the dwell; standby keeps more charge
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wake_cnt <= '0;
        end else if (state == clkctl_pkg::PWR_DOWN) begin
            wake_cnt <= dwell >> clkctl_pkg::WAKE_SHIFT; // [RULE13]
        end else if (state == clkctl_pkg::PWR_STBY) begin
            wake_cnt <= dwell >> clkctl_pkg::STBY_SHIFT; // [RULE12]
        end else if (wake_cnt != '0) begin
            wake_cnt <= wake_cnt - 20'h00001;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            OUT_OE_N <= 1'b1;
            REF_ON <= 1'b0;
            REF_BUF_ON <= 1'b0;
            BIAS_ON <= 1'b0;
            CLOCK_ON <= 1'b0;
            READY <= 1'b0;
        end else begin
            OUT_OE_N <= (state != clkctl_pkg::PWR_ON); // [RULE9]
            REF_ON <= (state != clkctl_pkg::PWR_DOWN); // [RULE11]
            REF_BUF_ON <= (state != clkctl_pkg::PWR_DOWN); // [RULE12]
            BIAS_ON <= (state == clkctl_pkg::PWR_ON)
                || (state == clkctl_pkg::PWR_WAKE); // [RULE11]
            CLOCK_ON <= (state == clkctl_pkg::PWR_ON); // [RULE11]
            READY <= (state == clkctl_pkg::PWR_ON);
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            INT_CLK <= 1'b0;
            SAMPLE_STROBE <= 1'b0;
            DCS_LOCKED <= 1'b0;
        end else begin
            INT_CLK <= d.phase_hi; // [RULE5]
            SAMPLE_STROBE <= d.tick; // [RULE14]
            DCS_LOCKED <= locked;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_steady4;
        (d.run && locked && d.ratio_m1 == 3'h3 && !accept)[*4];
    endsequence

    a_div_period: // [RULE1]
    assert property (d.tick && d.ratio_m1 == 3'h7 && !accept
        ##1 (d.run && d.ratio_m1 == 3'h7 && !accept)[*7] ##1 d.run
        |-> d.tick)
        else $error("divide by eight period wrong");

    a_realign_init: // [RULE4]
    assert property (accept && d.run && !pd_req && !stby_req
        |=> d.count == 3'h0 && d.tick)
        else $error("realign did not restart divider");

    a_sync_every: // [RULE3]
    assert property (sync_rise && cfg[0] && !cfg[1]
        |=> seen && d.count == 3'h0)
        else $error("pulse ignored in every-pulse mode");

    a_once_disarm: // [RULE15]
    assert property (accept && cfg[1] && !wr_hit
        |=> !armed ##0 (!sync_rise || !accept))
        else $error("one-shot not disarmed");

    a_half_duty: // [RULE5]
    assert property (d.tick ##0 s_steady4 |-> $past(d.phase_hi, 3)
        && $past(d.phase_hi, 2) && !$past(d.phase_hi) && !d.phase_hi)
        else $error("stabilised high time not half period");

    a_dcs_floor: // [RULE6]
    assert property (DIV_RATIO > 3'h5 |=> !DCS_LOCKED)
        else $error("stabiliser active below rate floor");

    a_pd_enter: // [RULE8]
    assert property (pd_req && state == clkctl_pkg::PWR_ON
        |=> state == clkctl_pkg::PWR_DOWN ##1 OUT_OE_N)
        else $error("power-down request not taken");

    a_pd_shutdown: // [RULE11]
    assert property (state == clkctl_pkg::PWR_DOWN
        |=> !REF_ON && !BIAS_ON && !CLOCK_ON && OUT_OE_N)
        else $error("blocks still powered in power-down");

    a_pin_leave: // [RULE10]
    assert property (state == clkctl_pkg::PWR_DOWN && !pd_req
        && !SPI_STANDBY |=> state == clkctl_pkg::PWR_WAKE)
        else $error("release did not start wake-up");

    a_stby_ref: // [RULE12]
    assert property (state == clkctl_pkg::PWR_STBY
        |=> REF_ON && !CLOCK_ON)
        else $error("standby lost reference");

    a_wake_scale: // [RULE13]
    assert property (state == clkctl_pkg::PWR_DOWN && !pd_req
        && !stby_req |=> wake_cnt == ($past(dwell) >> 4))
        else $error("wake time not scaled from dwell");
endmodule
`default_nettype wire

// *** clock_control_tb.sv ***
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none
module clock_control_tb;
    logic clk, reset_n, reg_write, dcs_enable, spi_pd, spi_stby;
    logic [12:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [2:0] div_ratio;
    logic int_clk, strobe, locked, oe_n, ref_on, buf_on, bias_on;
    logic clock_on, ready;
    wire logic sync_pin, pd_pin;
    int failures, check_count, cyc, a, d, hi, st, w64, w512, ws;

    pin_host host (.clk(clk), .sync_pin(sync_pin), .pd_pin(pd_pin));

    clock_control dut (.CLK(clk), .RESET_N(reset_n), .SYNC_PIN(sync_pin),
        .POWERDOWN_PIN(pd_pin), .REG_WRITE(reg_write),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .DIV_RATIO(div_ratio),
        .DCS_ENABLE(dcs_enable), .SPI_POWERDOWN(spi_pd),
        .SPI_STANDBY(spi_stby), .REG_RDATA(reg_rdata), .INT_CLK(int_clk),
        .SAMPLE_STROBE(strobe), .DCS_LOCKED(locked), .OUT_OE_N(oe_n),
        .REF_ON(ref_on), .REF_BUF_ON(buf_on), .BIAS_ON(bias_on),
        .CLOCK_ON(clock_on), .READY(ready));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) cyc <= cyc + 1;

    task automatic test_done();
        $display("Checks made %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Every step ends just after an edge, where all inputs are changed
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_wr(input logic [12:0] ad, input logic [7:0] v);
        reg_addr = ad;
        reg_wdata = v;
        reg_write = 1'b1;
        step(1);
        reg_write = 1'b0;
    endtask

    task automatic reg_rd(input logic [12:0] ad, input logic [7:0] v);
        reg_addr = ad;
        step(2);
        check("readback", v, reg_rdata);
    endtask

    function automatic logic [7:0] pw();
        pw = {2'b00, ref_on, buf_on, bias_on, clock_on, oe_n, ready};
    endfunction

    task automatic measure(input int win);
        hi = 0;
        st = 0;
        repeat (win) begin
            step(1);
            hi += (int_clk === 1'b1);
            st += (strobe === 1'b1);
        end
    endtask

    task automatic wait_strobe();
        for (int i = 0; i < 20; i++) begin
            step(1);
            if (strobe === 1'b1) begin
                a = cyc;
                return;
            end
        end
        failures++;
        test_done();
    endtask

    // Pulse starts at a known cycle count; k is that count modulo 8
    task automatic sync_chk(input int k, input int ph, input string what);
        while (cyc % 8 != k)
            step(1);
        host.pulse_sync();
        wait_strobe();
        check(what, 8'(ph % 8), 8'(a % 8));
    endtask

    task automatic wake_time(output int n);
        for (n = 0; n < 3000; n++) begin
            step(1);
            if (ready === 1'b1)
                return;
        end
        failures++;
        test_done();
    endtask

    initial begin
        reset_n = 1'b0;
        reg_write = 1'b0;
        reg_addr = 13'h0000;
        reg_wdata = 8'h00;
        div_ratio = 3'h0;
        dcs_enable = 1'b0;
        spi_pd = 1'b0;
        spi_stby = 1'b0;
        failures = 0;
        check_count = 0;
        cyc = 0;
        repeat (10) @(posedge clk);
        #1 reset_n = 1'b1;
        step(2);
        check("power at reset", 8'h3D, pw());
        reg_rd(clkctl_pkg::SYNC_CFG_ADDR, clkctl_pkg::SYNC_CFG_RESET);
        reg_wr(13'h0108, 8'h03);
        reg_rd(13'h0108, 8'h00);
        reg_rd(clkctl_pkg::SYNC_CFG_ADDR, 8'h00);
        reg_wr(clkctl_pkg::SYNC_CFG_ADDR, 8'hFF);
        reg_rd(clkctl_pkg::SYNC_CFG_ADDR, 8'h07);
        for (int n = 1; n <= 8; n++) begin
            div_ratio = 3'(n - 1);
            dcs_enable = 1'b0;
            step(20);
            measure(8 * n);
            check("high without lock", 8'h08, 8'(hi));
            if (n > 1)
                check("strobes", 8'h08, 8'(st));
            dcs_enable = 1'b1;
            step(100);
            check("early lock", 8'h00, {7'h00, locked});
            step(100);
            check("lock", 8'(n <= 6), {7'h00, locked});
            measure(8 * n);
            check("high locked", 8'(8 * (n <= 6 ? (n + 1) / 2 : 1)),
                8'(hi));
        end
        dcs_enable = 1'b0;
        div_ratio = 3'h7;
        reg_wr(clkctl_pkg::SYNC_CFG_ADDR, 8'h01);
        step(20);
        // Pin to strobe takes seven cycles: launch, three flops, edge,
        // realign, registered strobe
        d = 7;
        sync_chk(0, d, "first align");
        sync_chk(3, 3 + d, "every pulse");
        reg_wr(clkctl_pkg::SYNC_CFG_ADDR, 8'h03);
        reg_rd(clkctl_pkg::SYNC_CFG_ADDR, 8'h07);
        sync_chk(6, 6 + d, "once accepted");
        reg_rd(clkctl_pkg::SYNC_CFG_ADDR, 8'h0B);
        sync_chk(1, 6 + d, "once ignored");
        reg_wr(clkctl_pkg::SYNC_CFG_ADDR, 8'h03);
        sync_chk(4, 4 + d, "rearmed");
        reg_wr(clkctl_pkg::SYNC_CFG_ADDR, 8'h00);
        sync_chk(7, 4 + d, "disabled");
        spi_pd = 1'b1;
        step(4);
        check("serial down", 8'h02, pw());
        measure(16);
        check("clock stopped", 8'h00, 8'(st));
        step(44);
        spi_pd = 1'b0;
        wake_time(w64);
        step(2);
        check("resumed", 8'h3D, pw());
        host.set_pd(1'b1);
        step(6);
        check("pin down", 8'h02, pw());
        spi_stby = 1'b1;
        step(4);
        check("pin over standby", 8'h02, pw());
        step(500);
        host.set_pd(1'b0);
        spi_stby = 1'b0;
        wake_time(w512);
        check("longer wake", 8'h01, 8'(w512 > w64));
        spi_pd = 1'b1;
        host.set_pd(1'b1);
        step(10);
        host.set_pd(1'b0);
        step(10);
        check("held by serial", 8'h02, pw());
        spi_pd = 1'b0;
        wake_time(a);
        spi_stby = 1'b1;
        step(4);
        check("standby", 8'h32, pw());
        step(508);
        spi_stby = 1'b0;
        wake_time(ws);
        check("faster wake", 8'h01, 8'(ws < w512));
        test_done();
    end
endmodule
`default_nettype wire

// *** div_if.sv ***
// Carrier between the clock control and its divider core
`timescale 1ns/1ps
`default_nettype none
interface div_if;
    logic [2:0] ratio_m1;
    logic dcs_on;
    logic run;
    logic realign;
    logic [2:0] count;
    logic tick;
    logic phase_hi;
    modport ctrl (output ratio_m1, dcs_on, run, realign,
        input count, tick, phase_hi);
    modport core (input ratio_m1, dcs_on, run, realign,
        output count, tick, phase_hi);
endinterface
`default_nettype wire

// *** pin_host.sv ***
// Host model driving the alignment and power-down pins
`timescale 1ns/1ps
`default_nettype none
module pin_host (
    input wire logic clk,
    output logic sync_pin,
    output logic pd_pin
);
    initial begin
        sync_pin = 1'b0;
        pd_pin = 1'b0;
    end

    // Each level held four cycles, so the agreement filter always sees it
    task automatic pulse_sync();
        @(posedge clk) #1 sync_pin = 1'b1;
        repeat (4) @(posedge clk);
        #1 sync_pin = 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic set_pd(input logic v);
        @(posedge clk) #1 pd_pin = v;
    endtask
endmodule
`default_nettype wire

// *** pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pin,
    output logic level,
    output logic rise
);
    logic ff1;
    logic ff2;
    logic ff3;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ff1 <= 1'b0;
            ff2 <= 1'b0;
            ff3 <= 1'b0;
        end else begin
            ff1 <= pin;
            ff2 <= ff1;
            ff3 <= ff2;
        end
    end

    // A change counts only once the last two stages agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level <= 1'b0;
            rise <= 1'b0;
        end else begin
            rise <= (ff2 == ff3) && ff3 && !level;
            if (ff2 == ff3) begin
                level <= ff3;
            end
        end
    end
endmodule
`default_nettype wire
